// ---- rtl/olss_top.sv ----
// Output line source select, status lamps and register slave
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module olss_top
	import olss_pkg::*;
#(
	parameter int PPS_HALF_CYC = OLSS_PPS_HALF_CYC,
	parameter int BLINK_CYC    = OLSS_BLINK_CYC
)
(
	input  wire logic        clk,
	input  wire logic        rstn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// Internal camera sources
	input  wire logic        exposure_active,
	input  wire logic        frame_valid,
	input  wire logic        frame_trigger_delayed,
	input  wire logic        transfer_active,
	input  wire logic        transfer_start,
	input  wire logic        timer0_active,
	input  wire logic        logic_block0,
	// Ethernet link state
	input  wire logic        link_gigabit,
	input  wire logic        link_activity,
	// Pins
	input  wire logic        opto_input_line,
	output logic             opto_output_line,
	input  wire logic        bidir_open_collector_line_i,
	output logic             bidir_open_collector_line_o,
	output logic             bidir_open_collector_line_oe,
	output logic             led_green,
	output logic             led_yellow
);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [OLSS_SEL_W-1:0]   sel_opto_q;
	logic [OLSS_SEL_W-1:0]   sel_oc_q;
	logic [OLSS_CTRL_W-1:0]  ctrl_q;
	logic [OLSS_DEB_W-1:0]   deb_q;
	logic                    wr_pend_q;
	logic                    rd_pend_q;
	logic [7:0]              addr_q;
	logic                    ready_q;
	logic [31:0]             rdata_q;
	logic                    resp_q;
	logic                    in0_s1_q;
	logic                    in0_s2_q;
	logic                    in2_s1_q;
	logic                    in2_s2_q;
	logic                    deb_in0;
	logic                    deb_in2;
	logic                    raw_in2;
	logic [5:0]              us_cnt_q;
	logic                    tick_us_q;
	logic [OLSS_CNT_W-1:0]   pps_cnt_q;
	logic                    pps_q;
	logic [OLSS_CNT_W-1:0]   blink_cnt_q;
	logic                    blink_q;
	logic                    exp_d1_q;
	logic                    fv_d1_q;
	logic                    frame_busy_q;
	logic [OLSS_NUM_SRC-1:0] src_vec;
	logic                    opto_q;
	logic                    oc_level_q;
	logic                    oc_oe_q;
	logic                    green_q;
	logic                    yellow_q;
	logic                    addr_take;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Codes outside the list pick bit zero, which is tied low
	function automatic logic src_pick(
		input logic [OLSS_SEL_W-1:0]   sel,
		input logic [OLSS_NUM_SRC-1:0] vec
	);
		src_pick = vec[sel];
	endfunction

	function automatic logic [31:0] reg_read(
		input logic [7:0] a
	);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			OLSS_ADDR_LINE_SEL: begin
				r[OLSS_SEL_OPTO_LO +: OLSS_SEL_W] = sel_opto_q;
				r[OLSS_SEL_OC_LO +: OLSS_SEL_W]   = sel_oc_q;
			end
			OLSS_ADDR_LINE_CTRL: begin
				r[OLSS_CTRL_W-1:0] = ctrl_q;
			end
			OLSS_ADDR_DEBOUNCE: begin
				r[OLSS_DEB_W-1:0] = deb_q;
			end
			OLSS_ADDR_STATUS: begin
				r[8:0] = {yellow_q, green_q, pps_q, oc_level_q, opto_q,
				          deb_in2, deb_in0, in2_s2_q, in0_s2_q};
			end
			default: begin
				r = 32'h0000_0000;
			end
		endcase
		reg_read = r;
	endfunction

	// ----------------------------------------
	// AHB-Lite slave
	// ----------------------------------------
	// Reads take one wait state so a write in the prior data phase is seen
	assign addr_take = hsel && hready && htrans[1];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= addr_take && hwrite;
			rd_pend_q <= addr_take && !hwrite;
			if (addr_take) begin
				addr_q <= {haddr[7:2], 2'b00};
			end
		end else begin
			rd_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ready_q <= 1'b1;
		end else if (addr_take && !hwrite) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_pend_q) begin
			rdata_q <= reg_read(addr_q);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			resp_q <= 1'b0;
		end else begin
			resp_q <= 1'b0;
		end
	end

	assign hreadyout = ready_q;
	assign hrdata    = rdata_q;
	assign hresp     = resp_q;

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sel_opto_q <= OLSS_SEL_RESET;
			sel_oc_q   <= OLSS_SEL_RESET;
		end else if (wr_pend_q && addr_q == OLSS_ADDR_LINE_SEL) begin
			sel_opto_q <= hwdata[OLSS_SEL_OPTO_LO +: OLSS_SEL_W];
			sel_oc_q   <= hwdata[OLSS_SEL_OC_LO +: OLSS_SEL_W];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= OLSS_CTRL_RESET;
		end else if (wr_pend_q && addr_q == OLSS_ADDR_LINE_CTRL) begin
			ctrl_q <= hwdata[OLSS_CTRL_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			deb_q <= OLSS_DEB_RESET;
		end else if (wr_pend_q && addr_q == OLSS_ADDR_DEBOUNCE) begin
			deb_q <= hwdata[OLSS_DEB_W-1:0];
		end
	end

	// ----------------------------------------
	// Pin synchronisers and debounce
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			in0_s1_q <= 1'b0;
			in0_s2_q <= 1'b0;
			in2_s1_q <= 1'b0;
			in2_s2_q <= 1'b0;
		end else begin
			in0_s1_q <= opto_input_line;
			in0_s2_q <= in0_s1_q;
			in2_s1_q <= bidir_open_collector_line_i;
			in2_s2_q <= in2_s1_q;
		end
	end

	// Driven as output, the line reads its own drive; filter sees idle low then
	assign raw_in2 = ctrl_q[OLSS_CTRL_OC_DIR] ? 1'b0 : in2_s2_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			us_cnt_q  <= 6'h00;
			tick_us_q <= 1'b0;
		end else if (us_cnt_q == 6'(OLSS_US_CYC - 1)) begin
			us_cnt_q  <= 6'h00;
			tick_us_q <= 1'b1;
		end else begin
			us_cnt_q  <= us_cnt_q + 6'h01;
			tick_us_q <= 1'b0;
		end
	end

	olss_debounce u_deb_in0 (
		.clk      (clk),
		.rstn     (rstn),
		.tick_us  (tick_us_q),
		.time_us  (deb_q),
		.raw      (in0_s2_q),
		.filtered (deb_in0)
	);

	olss_debounce u_deb_in2 (
		.clk      (clk),
		.rstn     (rstn),
		.tick_us  (tick_us_q),
		.time_us  (deb_q),
		.raw      (raw_in2),
		.filtered (deb_in2)
	);

	// ----------------------------------------
	// Pulse per second
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pps_cnt_q <= '0;
			pps_q     <= 1'b0;
		end else if (pps_cnt_q == OLSS_CNT_W'(PPS_HALF_CYC - 1)) begin
			pps_cnt_q <= '0;
			pps_q     <= ~pps_q;
		end else begin
			pps_cnt_q <= pps_cnt_q + 25'h0000001;
		end
	end

	// ----------------------------------------
	// Frame trigger wait
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			exp_d1_q <= 1'b0;
			fv_d1_q  <= 1'b0;
		end else begin
			exp_d1_q <= exposure_active;
			fv_d1_q  <= frame_valid;
		end
	end

	// Exposure start wins over an image end in the same cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			frame_busy_q <= 1'b0;
		end else if (exposure_active && !exp_d1_q) begin
			frame_busy_q <= 1'b1;
		end else if (fv_d1_q && !frame_valid) begin
			frame_busy_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Source vector and line drive
	// ----------------------------------------
	always_comb begin
		src_vec                      = '0;
		src_vec[OLSS_SRC_FRAME_WAIT] = ~frame_busy_q;
		src_vec[OLSS_SRC_FRAME_TRIG] = frame_trigger_delayed;
		src_vec[OLSS_SRC_EXPOSURE]   = exposure_active;
		src_vec[OLSS_SRC_ACQ_WAIT]   = ~transfer_active;
		src_vec[OLSS_SRC_ACQ_TRIG]   = transfer_start;
		src_vec[OLSS_SRC_READOUT]    = frame_valid;
		src_vec[OLSS_SRC_DEB_IN0]    = deb_in0;
		src_vec[OLSS_SRC_DEB_IN2]    = deb_in2;
		src_vec[OLSS_SRC_USER1]      = ctrl_q[OLSS_CTRL_USER1];
		src_vec[OLSS_SRC_USER2]      = ctrl_q[OLSS_CTRL_USER2];
		src_vec[OLSS_SRC_TIMER0]     = timer0_active;
		src_vec[OLSS_SRC_SW0]        = ctrl_q[OLSS_CTRL_SW0];
		src_vec[OLSS_SRC_SW1]        = ctrl_q[OLSS_CTRL_SW1];
		src_vec[OLSS_SRC_LOGIC0]     = logic_block0;
		src_vec[OLSS_SRC_PPS]        = pps_q;
	end

	// Registered so a selection change cannot leave a glitch on the pin
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			opto_q     <= 1'b0;
			oc_level_q <= 1'b0;
		end else begin
			opto_q     <= src_pick(sel_opto_q, src_vec);
			oc_level_q <= src_pick(sel_oc_q, src_vec);
		end
	end

	// Open collector: only pulls low; high level is the external pull-up
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			oc_oe_q <= 1'b0;
		end else begin
			oc_oe_q <= ctrl_q[OLSS_CTRL_OC_DIR] && !src_pick(sel_oc_q, src_vec);
		end
	end

	assign opto_output_line             = opto_q;
	assign bidir_open_collector_line_o  = 1'b0;
	assign bidir_open_collector_line_oe = oc_oe_q;

	// ----------------------------------------
	// Status lamps
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
		end else if (blink_cnt_q == OLSS_CNT_W'(BLINK_CYC - 1)) begin
			blink_cnt_q <= '0;
			blink_q     <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 25'h0000001;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			green_q  <= 1'b0;
			yellow_q <= 1'b0;
		end else begin
			green_q  <= link_gigabit;
			yellow_q <= link_activity && blink_q;
		end
	end

	assign led_green  = green_q;
	assign led_yellow = yellow_q;

endmodule
`default_nettype wire

// ---- rtl/olss_pkg.sv ----
// Constants for the output line source select block
//
// Contract
// - Software picks a source for each output line.
// - Both selections reset to code one.
// - Frame trigger wait low from exposure to image out.
// - Frame trigger internal gives the delayed accepted trigger.
// - Exposure active high for the whole exposure.
// - Acquisition trigger wait low during image transfer.
// - Acquisition trigger internal gives transfer start signal.
// - Sensor readout gives the frame valid level.
// - Debounced input lines are selectable sources.
// - Two user outputs give software static levels.
// - Timer active gives the timer counter signal.
// - Two software signals give their assigned levels.
// - Logic block source passes result unchanged.
// - Pulse per second: one second period, half duty.
// - Open collector line is input or output.
// - Gigabit idle: green on, yellow off.
// - Gigabit transferring: green on, yellow blinking.
// - 100 megabit: green off, yellow blinks when transferring.
// - Pulses shorter than debounce time are discarded.
package olss_pkg;

	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] OLSS_ADDR_LINE_SEL  = 8'h00;
	localparam logic [7:0] OLSS_ADDR_LINE_CTRL = 8'h04;
	localparam logic [7:0] OLSS_ADDR_DEBOUNCE  = 8'h08;
	localparam logic [7:0] OLSS_ADDR_STATUS    = 8'h0C;

	// ----------------------------------------
	// Field positions and widths
	// ----------------------------------------
	localparam int OLSS_SEL_W       = 4;
	localparam int OLSS_SEL_OPTO_LO = 0;
	localparam int OLSS_SEL_OC_LO   = 8;
	localparam int OLSS_CTRL_OC_DIR = 0;
	localparam int OLSS_CTRL_USER1  = 1;
	localparam int OLSS_CTRL_USER2  = 2;
	localparam int OLSS_CTRL_SW0    = 3;
	localparam int OLSS_CTRL_SW1    = 4;
	localparam int OLSS_CTRL_W      = 5;
	localparam int OLSS_DEB_W       = 16;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [3:0]  OLSS_SEL_RESET  = 4'h1;
	localparam logic [4:0]  OLSS_CTRL_RESET = 5'h00;
	localparam logic [15:0] OLSS_DEB_RESET  = 16'h000A;

	// ----------------------------------------
	// Source selection codes
	// ----------------------------------------
	localparam logic [3:0] OLSS_SRC_FRAME_WAIT = 4'h1;
	localparam logic [3:0] OLSS_SRC_FRAME_TRIG = 4'h2;
	localparam logic [3:0] OLSS_SRC_EXPOSURE   = 4'h3;
	localparam logic [3:0] OLSS_SRC_ACQ_WAIT   = 4'h4;
	localparam logic [3:0] OLSS_SRC_ACQ_TRIG   = 4'h5;
	localparam logic [3:0] OLSS_SRC_READOUT    = 4'h6;
	localparam logic [3:0] OLSS_SRC_DEB_IN0    = 4'h7;
	localparam logic [3:0] OLSS_SRC_DEB_IN2    = 4'h8;
	localparam logic [3:0] OLSS_SRC_USER1      = 4'h9;
	localparam logic [3:0] OLSS_SRC_USER2      = 4'hA;
	localparam logic [3:0] OLSS_SRC_TIMER0     = 4'hB;
	localparam logic [3:0] OLSS_SRC_SW0        = 4'hC;
	localparam logic [3:0] OLSS_SRC_SW1        = 4'hD;
	localparam logic [3:0] OLSS_SRC_LOGIC0     = 4'hE;
	localparam logic [3:0] OLSS_SRC_PPS        = 4'hF;
	localparam int         OLSS_NUM_SRC        = 16;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int OLSS_CLK_HZ       = 50000000;
	localparam int OLSS_US_PER_S     = 1000000;
	localparam int OLSS_TICK_US      = 1;
	localparam int OLSS_US_CYC       = OLSS_CLK_HZ / OLSS_US_PER_S * OLSS_TICK_US;
	localparam int OLSS_PPS_HALF_MS  = 500;
	localparam int OLSS_PPS_HALF_CYC = OLSS_CLK_HZ / 1000 * OLSS_PPS_HALF_MS;
	localparam int OLSS_BLINK_MS     = 50;
	localparam int OLSS_BLINK_CYC    = OLSS_CLK_HZ / 1000 * OLSS_BLINK_MS;
	localparam int OLSS_CNT_W        = 25;

endpackage

// ---- rtl/olss_debounce.sv ----
// Pulse width filter for one synchronised input line
`timescale 1ns/1ps
`default_nettype none
module olss_debounce
	import olss_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic                  tick_us,
	input  wire logic [OLSS_DEB_W-1:0] time_us,
	input  wire logic                  raw,
	output logic                       filtered
);

	logic [OLSS_DEB_W-1:0] cnt_q;
	logic                  part_q;
	logic                  out_q;

	// ----------------------------------------
	// Stability counter
	// ----------------------------------------
	// Any change back to the held level restarts the count, so short pulses vanish
	// First tick after a change ends only part of a microsecond, so it is not counted
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q  <= '0;
			part_q <= 1'b0;
		end else if (raw == out_q) begin
			cnt_q  <= '0;
			part_q <= 1'b0;
		end else if (tick_us && !part_q) begin
			part_q <= 1'b1;
		end else if (tick_us && cnt_q < time_us) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			out_q <= 1'b0;
		end else if (raw != out_q && cnt_q >= time_us && (part_q || time_us == '0)) begin
			out_q <= raw;
		end
	end

	assign filtered = out_q;

endmodule
`default_nettype wire

// ---- rtl/olss_top_end.sv ----
// Empty unit; the block's logic lives in the top and filter files
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- bench/olss_checker.sv ----
// Port checker for the output line source select block
`timescale 1ns/1ps
`default_nettype none
module olss_checker
	import olss_pkg::*;
#(
	parameter int BLINK_CYC = 4
)
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        exposure_active,
	input wire logic        frame_valid,
	input wire logic        frame_trigger_delayed,
	input wire logic        transfer_active,
	input wire logic        transfer_start,
	input wire logic        timer0_active,
	input wire logic        logic_block0,
	input wire logic        link_gigabit,
	input wire logic        link_activity,
	input wire logic        opto_output_line,
	input wire logic        led_yellow,
	input wire logic        led_green
);
	// ----
	// Shadow of the opto line selection
	// ----
	logic       wr_q;
	logic [7:0] a_q;
	logic [3:0] so_q;
	logic       ly_q;
	int         run_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_q <= 1'b0;
			a_q  <= 8'h00;
		end else if (hready) begin
			wr_q <= hsel & htrans[1] & hwrite;
			a_q  <= haddr;
		end
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			so_q <= OLSS_SEL_RESET;
		else if (hready && wr_q && a_q == OLSS_ADDR_LINE_SEL)
			so_q <= hwdata[3:0];
	end
	// Run of unchanged yellow lamp while busy
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ly_q  <= 1'b0;
			run_q <= 0;
		end else begin
			ly_q  <= led_yellow;
			run_q <= (!link_activity || led_yellow != ly_q) ? 0 : run_q + 1;
		end
	end
	// ----
	// Assertions
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_follow(logic [3:0] c, logic s);
		so_q == c |=> opto_output_line == $past(s);
	endproperty
	chk_reset_ready: assert property ($rose(rstn) |=> opto_output_line)
		else $error("opto line not ready after reset");
	chk_exposure_src: assert property (p_follow(OLSS_SRC_EXPOSURE, exposure_active))
		else $error("exposure source not followed");
	chk_frame_trig: assert property (p_follow(OLSS_SRC_FRAME_TRIG, frame_trigger_delayed))
		else $error("frame trigger source not followed");
	chk_readout_src: assert property (p_follow(OLSS_SRC_READOUT, frame_valid))
		else $error("readout source not followed");
	chk_timer_src: assert property (p_follow(OLSS_SRC_TIMER0, timer0_active))
		else $error("timer source not followed");
	chk_logic_src: assert property (p_follow(OLSS_SRC_LOGIC0, logic_block0))
		else $error("logic block source not followed");
	chk_acq_start: assert property (p_follow(OLSS_SRC_ACQ_TRIG, transfer_start))
		else $error("transfer start source not followed");
	chk_acq_wait: assert property (so_q == OLSS_SRC_ACQ_WAIT && transfer_active |=> !opto_output_line)
		else $error("acquisition wait not low in transfer");
	chk_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	chk_green_on: assert property (link_gigabit |=> led_green)
		else $error("green lamp dark at gigabit");
	chk_green_off: assert property (!link_gigabit |=> !led_green)
		else $error("green lamp lit at low speed");
	chk_yellow_idle: assert property (!link_activity |=> !led_yellow)
		else $error("yellow lamp lit when idle");
	chk_yellow_blink: assert property (run_q <= BLINK_CYC + 2)
		else $error("yellow lamp not blinking");
	cov_exposure: cover property (so_q == OLSS_SRC_EXPOSURE && exposure_active);
	cov_blink: cover property (link_activity && led_yellow);
	cov_read: cover property (!hreadyout);
endmodule
bind olss_top olss_checker #(.BLINK_CYC(BLINK_CYC)) chk_u (.clk, .rstn, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hreadyout, .exposure_active, .frame_valid, .frame_trigger_delayed,
	.transfer_active, .transfer_start, .timer0_active, .logic_block0, .link_gigabit,
	.link_activity, .opto_output_line, .led_yellow, .led_green);
`default_nettype wire

// ---- bench/olss_ext_equip.sv ----
// External equipment model on the camera line pins
`timescale 1ns/1ps
`default_nettype none
module olss_ext_equip (
	input  wire logic clk,
	input  wire logic opto_lvl,
	input  wire logic ext_low,
	input  wire logic oc_o,
	input  wire logic oc_oe,
	output logic      opto_drive,
	output logic      oc_wire
);
	// Sensor drive, changes only after an edge
	always @(posedge clk) opto_drive <= opto_lvl;
	// Pull-up wins unless a party sinks the line
	assign oc_wire = ~((oc_oe & ~oc_o) | ext_low);
endmodule
`default_nettype wire

// ---- bench/olss_tb_top.sv ----
// Self-checking bench of the output line source select block
`timescale 1ns/1ps
`default_nettype none
module olss_tb_top;
	import olss_pkg::*;
	localparam int PPS = 8;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [7:0]  haddr = 8'h00;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [6:0]  src = 7'h00;
	logic [1:0]  lnk = 2'h0;
	logic        opto_lvl = 1'b0;
	logic        ext_low = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, opto_in, oc_w, oc_o, oc_oe, opto_out, led_g, led_y;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          seed = 32'h8fb2;
	always #10 clk = ~clk;
	olss_top #(.PPS_HALF_CYC(PPS), .BLINK_CYC(4)) dut_u (.clk(clk), .rstn(rstn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.exposure_active(src[0]), .frame_valid(src[1]), .frame_trigger_delayed(src[2]),
		.transfer_active(src[3]), .transfer_start(src[4]), .timer0_active(src[5]),
		.logic_block0(src[6]), .link_gigabit(lnk[0]), .link_activity(lnk[1]),
		.opto_input_line(opto_in), .opto_output_line(opto_out),
		.bidir_open_collector_line_i(oc_w), .bidir_open_collector_line_o(oc_o),
		.bidir_open_collector_line_oe(oc_oe), .led_green(led_g), .led_yellow(led_y));
	olss_ext_equip ext_u (.clk(clk), .opto_lvl(opto_lvl), .ext_low(ext_low), .oc_o(oc_o),
		.oc_oe(oc_oe), .opto_drive(opto_in), .oc_wire(oc_w));
	function automatic logic exp_lvl(input logic [3:0] c, input logic [4:0] k,
		input logic [6:0] s, input logic d0, input logic d2);
		case (c)
			OLSS_SRC_FRAME_TRIG: return s[2];
			OLSS_SRC_EXPOSURE:   return s[0];
			OLSS_SRC_ACQ_WAIT:   return ~s[3];
			OLSS_SRC_ACQ_TRIG:   return s[4];
			OLSS_SRC_READOUT:    return s[1];
			OLSS_SRC_DEB_IN0:    return d0;
			OLSS_SRC_DEB_IN2:    return d2;
			OLSS_SRC_USER1:      return k[OLSS_CTRL_USER1];
			OLSS_SRC_USER2:      return k[OLSS_CTRL_USER2];
			OLSS_SRC_TIMER0:     return s[5];
			OLSS_SRC_SW0:        return k[OLSS_CTRL_SW0];
			OLSS_SRC_SW1:        return k[OLSS_CTRL_SW1];
			OLSS_SRC_LOGIC0:     return s[6];
			default:             return 1'b0;
		endcase
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wt();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 20);
		if (k >= 20)
			n_mismatch++;
	endtask
	// Address phase held until ready, then data phase until ready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wt();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic mon(input int n, inout int hi, input logic v);
		repeat (n) begin
			@(posedge clk);
			hi += (v ? opto_out : led_y);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#400000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		logic [31:0] q;
		logic [4:0]  k;
		logic [3:0]  c;
		int          r, i, hi;
		logic        v;
		cyc(5);
		rstn <= 1'b1;
		// ----
		// Reset values, unmapped place
		// ----
		chk(opto_out, 1'b0);
		bus(1'b0, OLSS_ADDR_LINE_SEL, 32'h0, q);
		chk(q, 32'h0000_0101);
		chk({hresp, oc_o}, 2'b00);
		bus(1'b0, OLSS_ADDR_DEBOUNCE, 32'h0, q);
		chk(q, 32'h0000_000A);
		wr(8'h10, 32'hFFFF_FFFF);
		bus(1'b0, 8'h10, 32'h0, q);
		chk(q, 32'h0);
		chk(opto_out, 1'b1);
		$display("test 1 done");
		// Frame wait: low from exposure to end of readout
		src <= 7'h01;
		cyc(3);
		chk(opto_out, 1'b0);
		src <= 7'h02;
		cyc(3);
		chk(opto_out, 1'b0);
		src <= 7'h00;
		cyc(3);
		chk(opto_out, 1'b1);
		$display("test 2 done");
		// Source codes 2 to 14 on both lines, random levels
		wr(OLSS_ADDR_DEBOUNCE, 32'h1);
		for (i = 0; i < 26; i++) begin
			c = 4'(2 + i % 13);
			r = $random(seed);
			k = r[4:0];
			src <= r[14:8];
			opto_lvl <= r[16];
			ext_low <= r[17];
			wr(OLSS_ADDR_LINE_CTRL, {27'h0, k});
			wr(OLSS_ADDR_LINE_SEL, {20'h0, c, 4'h0, c});
			cyc(200);
			chk(opto_out, exp_lvl(c, k, src, opto_lvl, ~k[0] & ~ext_low));
			chk(oc_oe, k[0] & ~exp_lvl(c, k, src, opto_lvl, 1'b0));
			bus(1'b0, OLSS_ADDR_STATUS, 32'h0, q);
			chk(q[3:2], {~k[0] & ~ext_low, opto_lvl});
		end
		$display("test 3 done");
		// Short pulse lost, long pulse passes
		wr(OLSS_ADDR_DEBOUNCE, 32'h2);
		wr(OLSS_ADDR_LINE_SEL, 32'h0000_0007);
		opto_lvl <= 1'b0;
		cyc(300);
		hi = 0;
		opto_lvl <= 1'b1;
		mon(95, hi, 1'b1);
		opto_lvl <= 1'b0;
		mon(300, hi, 1'b1);
		chk(hi, 0);
		opto_lvl <= 1'b1;
		cyc(250);
		chk(opto_out, 1'b1);
		$display("test 4 done");
		// Square wave halves of equal length
		wr(OLSS_ADDR_LINE_SEL, 32'h0000_000F);
		cyc(3);
		v = opto_out;
		hi = 0;
		while (opto_out === v && hi < 100) begin
			@(posedge clk);
			hi++;
		end
		for (i = 0; i < 2; i++) begin
			v = opto_out;
			hi = 0;
			do begin
				@(posedge clk);
				hi++;
			end while (opto_out === v && hi < 100);
			chk(hi, PPS);
		end
		$display("test 5 done");
		// Lamps for each speed and activity
		for (i = 0; i < 4; i++) begin
			lnk <= i[1:0];
			cyc(2);
			hi = 0;
			mon(12, hi, 1'b0);
			chk(led_g, i[0]);
			chk(hi != 0 && hi != 12, i[1]);
		end
		$display("test 6 done");
		complete_run();
	end
endmodule
`default_nettype wire
